// *** hw/sync_clamp_pkg.sv ***
// Purpose: Shared constants for the sync and clamp input select block
// Assumes: APB register index times four gives the byte address
// Notes:   Times are in pixel clocks of the sampling clock
package sync_clamp_pkg;

	// Register indices; byte address is index times four
	localparam logic [7:0] IDX_CLAMP_DELAY = 8'h05;
	localparam logic [7:0] IDX_CLAMP_DUR   = 8'h06;
	localparam logic [7:0] IDX_SYNC_CTRL   = 8'h0E;
	localparam logic [7:0] IDX_CLAMP_CTRL  = 8'h0F;
	localparam logic [7:0] IDX_SOG_THR     = 8'h10;
	localparam logic [7:0] IDX_STATUS      = 8'h11;

	// Field positions
	localparam int LINE_SYNC_EDGE_BIT = 6;
	localparam int EXT_CLAMP_SEL_BIT  = 7;
	localparam int CLAMP_SENSE_BIT    = 6;

	// Reset values
	localparam logic       EDGE_SEL_RST  = 1'h0;
	localparam logic       EXT_SEL_RST   = 1'h0;
	localparam logic       SENSE_RST     = 1'h1;
	localparam logic [7:0] DELAY_RST     = 8'h08;
	localparam logic [7:0] DUR_RST       = 8'h14;

	// Comparator threshold in millivolts above the negative peak
	localparam int SOG_STEP_MV    = 10;
	localparam int SOG_MIN_MV     = 10;
	localparam int SOG_MAX_MV     = 330;
	localparam int SOG_DEFAULT_MV = 150;
	localparam int SOG_CODE_W     = 6;
	localparam logic [5:0] SOG_CODE_MAX =
		6'((SOG_MAX_MV - SOG_MIN_MV) / SOG_STEP_MV);
	localparam logic [5:0] SOG_CODE_RST =
		6'((SOG_DEFAULT_MV - SOG_MIN_MV) / SOG_STEP_MV);

	// Internal clamp sequencer
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_DELAY = 3'h2,
		ST_CLAMP = 3'h4
	} clamp_state_t;

endpackage

// *** hw/sync_stage2.sv ***
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sync_stage2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
`default_nettype wire

// *** hw/sync_and_clamp_input_select.sv ***
// Purpose: Line sync edge select, embedded sync conditioning and clamp timing
// Assumes: APB slave, zero wait states, pins asynchronous to pclk
// Notes:   Clamp delay and duration count pixel clocks
`timescale 1ns/100ps
`default_nettype none
module sync_and_clamp_input_select #(
	parameter int CNT_W  = 8,
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Pins
	input  wire logic              line_sync_in,
	input  wire logic              clamp_ext_in,
	input  wire logic              embedded_sync_input,
	// Outputs
	output logic                   embedded_sync_output,
	output logic [5:0]             sog_threshold_code,
	output logic                   line_sync_lead,
	output logic                   clamp_out
);

	////////////////////////////////////////////////////////////////////////
	// Register decode

	function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hits = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
	endfunction

	logic             edge_sel_q;
	logic             ext_sel_q;
	logic             sense_q;
	logic [CNT_W-1:0] delay_q;
	logic [CNT_W-1:0] dur_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             sync_prev_q;
	sync_clamp_pkg::clamp_state_t state_q;
	sync_clamp_pkg::clamp_state_t state_d;

	wire logic setup    = psel && !penable;
	wire logic wr_go    = psel && penable && pready && pwrite;
	wire logic hit_dly  = hits(paddr, sync_clamp_pkg::IDX_CLAMP_DELAY);
	wire logic hit_dur  = hits(paddr, sync_clamp_pkg::IDX_CLAMP_DUR);
	wire logic hit_sync = hits(paddr, sync_clamp_pkg::IDX_SYNC_CTRL);
	wire logic hit_clmp = hits(paddr, sync_clamp_pkg::IDX_CLAMP_CTRL);
	wire logic hit_sog  = hits(paddr, sync_clamp_pkg::IDX_SOG_THR);
	wire logic hit_stat = hits(paddr, sync_clamp_pkg::IDX_STATUS);
	wire logic hit_any  = hit_dly || hit_dur || hit_sync || hit_clmp || hit_sog || hit_stat;

	// Saturate so software cannot program beyond the top of the range
	wire logic [5:0] sog_wr = (pwdata[5:0] > sync_clamp_pkg::SOG_CODE_MAX) ?
		sync_clamp_pkg::SOG_CODE_MAX : pwdata[5:0];

	logic [2:0] pins_sync;
	wire logic  ls_lvl  = pins_sync[0];
	wire logic  ext_lvl = pins_sync[1];
	wire logic  sog_lvl = pins_sync[2];

	wire logic [31:0] rd_sync = 32'(edge_sel_q) << sync_clamp_pkg::LINE_SYNC_EDGE_BIT;
	wire logic [31:0] rd_clmp = (32'(ext_sel_q) << sync_clamp_pkg::EXT_CLAMP_SEL_BIT)
		| (32'(sense_q) << sync_clamp_pkg::CLAMP_SENSE_BIT);
	wire logic [31:0] rd_stat = 32'({state_q, ext_lvl, clamp_out, ls_lvl});
	wire logic [31:0] rd_data =
		hit_dly  ? 32'(delay_q) :
		hit_dur  ? 32'(dur_q) :
		hit_sync ? rd_sync :
		hit_clmp ? rd_clmp :
		hit_sog  ? 32'(sog_threshold_code) :
		hit_stat ? rd_stat : 32'h0;

	// One-cycle access phase: answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit_any;
			prdata  <= (setup && !pwrite) ? rd_data : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_sel_q         <= sync_clamp_pkg::EDGE_SEL_RST;
			ext_sel_q          <= sync_clamp_pkg::EXT_SEL_RST;
			sense_q            <= sync_clamp_pkg::SENSE_RST;
			delay_q            <= CNT_W'(sync_clamp_pkg::DELAY_RST);
			dur_q              <= CNT_W'(sync_clamp_pkg::DUR_RST);
			sog_threshold_code <= sync_clamp_pkg::SOG_CODE_RST;
		end else if (wr_go) begin
			if (hit_sync) begin
				edge_sel_q <= pwdata[sync_clamp_pkg::LINE_SYNC_EDGE_BIT];
			end else if (hit_clmp) begin
				ext_sel_q <= pwdata[sync_clamp_pkg::EXT_CLAMP_SEL_BIT];
				sense_q   <= pwdata[sync_clamp_pkg::CLAMP_SENSE_BIT];
			end else if (hit_dly) begin
				delay_q <= pwdata[CNT_W-1:0];
			end else if (hit_dur) begin
				dur_q <= pwdata[CNT_W-1:0];
			end else if (hit_sog) begin
				sog_threshold_code <= sog_wr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	sync_stage2 #(
		.WIDTH(3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({embedded_sync_input, clamp_ext_in, line_sync_in}),
		.sync_out(pins_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Line sync edges

	wire logic ls_change = ls_lvl != sync_prev_q;
	// Leading edge lands on the level the select bit names
	wire logic ls_lead   = ls_change && (ls_lvl == edge_sel_q);
	wire logic ls_trail  = ls_change && (ls_lvl != edge_sel_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_prev_q          <= 1'h0;
			line_sync_lead       <= 1'h0;
			embedded_sync_output <= 1'h0;
		end else begin
			sync_prev_q          <= ls_lvl;
			line_sync_lead       <= ls_lead;
			embedded_sync_output <= sog_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Internal clamp sequencer

	// A new trailing edge restarts the sequence, so a short line never
	// leaves a stale clamp running into active video
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			sync_clamp_pkg::ST_DELAY: begin
				cnt_d = cnt_q - CNT_W'(1);
				if (cnt_q == CNT_W'(1)) begin
					state_d = (dur_q != '0) ? sync_clamp_pkg::ST_CLAMP : sync_clamp_pkg::ST_IDLE;
					cnt_d   = dur_q;
				end
			end
			sync_clamp_pkg::ST_CLAMP: begin
				cnt_d = cnt_q - CNT_W'(1);
				if (cnt_q == CNT_W'(1)) begin
					state_d = sync_clamp_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = sync_clamp_pkg::ST_IDLE;
				cnt_d   = '0;
			end
		endcase
		if (ls_trail) begin
			if (delay_q != '0) begin
				state_d = sync_clamp_pkg::ST_DELAY;
				cnt_d   = delay_q;
			end else if (dur_q != '0) begin
				state_d = sync_clamp_pkg::ST_CLAMP;
				cnt_d   = dur_q;
			end else begin
				state_d = sync_clamp_pkg::ST_IDLE;
				cnt_d   = '0;
			end
		end
	end

	wire logic int_clamp = state_d == sync_clamp_pkg::ST_CLAMP;
	wire logic ext_clamp = ext_lvl == sense_q;
	wire logic clamp_d   = ext_sel_q ? ext_clamp : int_clamp;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= sync_clamp_pkg::ST_IDLE;
			cnt_q     <= '0;
			clamp_out <= 1'h0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			clamp_out <= clamp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_lead_falling_edge: assert property (
		(!edge_sel_q && sync_prev_q && !ls_lvl) |=> line_sync_lead)
		else $error("falling leading edge missed");

	a_lead_rising_edge: assert property (
		(edge_sel_q && !sync_prev_q && ls_lvl) |=> line_sync_lead)
		else $error("rising leading edge missed");

	a_trail_ignored: assert property (
		line_sync_lead |-> ($past(ls_lvl) == $past(edge_sel_q)) && ($past(sync_prev_q) != $past(ls_lvl)))
		else $error("pulse on a trailing edge");

	a_sync_two_flops: assert property (
		line_sync_lead |-> $past(line_sync_in, 3) != $past(line_sync_in, 4))
		else $error("line sync edge not delayed by synchroniser");

	a_ext_clamp_sense: assert property (
		(ext_sel_q && $stable(ext_sel_q)) ##1 1'h1 |-> clamp_out == ($past(ext_lvl) == $past(sense_q)))
		else $error("external clamp level mismatch");

	a_ext_pin_ignored: assert property (
		(!ext_sel_q && state_q == sync_clamp_pkg::ST_IDLE && !ls_trail) |=> !clamp_out)
		else $error("clamp outside internal window");

	a_clamp_after_delay: assert property (
		(!ext_sel_q && ls_trail && delay_q == CNT_W'(2) && dur_q != '0 && !wr_go)
		|=> (!clamp_out && !ls_trail) ##1 (!clamp_out && !ls_trail) ##1 clamp_out)
		else $error("internal clamp delay wrong");

	a_clamp_within_dur: assert property (
		state_q == sync_clamp_pkg::ST_CLAMP |-> cnt_q <= dur_q || $past(wr_go))
		else $error("clamp duration count above setting");

	a_sog_range: assert property (
		sog_threshold_code <= sync_clamp_pkg::SOG_CODE_MAX)
		else $error("threshold code out of range");

	a_sog_copy: assert property (
		$past(embedded_sync_input, 3) == $past(embedded_sync_input, 2) |->
		embedded_sync_output == $past(embedded_sync_input, 2))
		else $error("embedded sync output not a copy");

endmodule
`default_nettype wire

// *** sim/sync_source_model.sv ***
// Purpose: Graphics source and system logic driving line sync and clamp pins
// Assumes: One line per start pulse, sync active for 8 pclk
// Notes:   Idle sync sits at the inactive level of the chosen polarity
`timescale 1ns/100ps
`default_nettype none
module sync_source_model (
	// Control from the bench
	input  wire logic pclk,
	input  wire logic start,
	input  wire logic pol,
	input  wire logic clamp_en,
	// Pins
	output logic      line_sync_in,
	output logic      clamp_ext_in
);
	logic [5:0] cnt_q = 6'h00;

	always_ff @(posedge pclk) begin
		if (start)
			cnt_q <= 6'h01;
		else if (cnt_q != 6'h00 && cnt_q < 6'h28)
			cnt_q <= cnt_q + 6'h01;
		else
			cnt_q <= 6'h00;
	end

	assign line_sync_in = (cnt_q >= 6'h01 && cnt_q <= 6'h08) ? pol : ~pol;
	// Pulse only over the back porch; held low when the pin is unused
	assign clamp_ext_in = clamp_en && cnt_q >= 6'h0C && cnt_q <= 6'h11;
endmodule
`default_nettype wire

// *** sim/sync_and_clamp_input_select_test.sv ***
// Purpose: Self-checking bench for the sync and clamp input select block
// Assumes: APB answers within a few cycles; pins driven on rising edges
// Notes:   Counters sample on rising edges; checks read them at falling edges
`timescale 1ns/100ps
`default_nettype none
module sync_and_clamp_input_select_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, es_out, lead, clamp_out, ls_pin, cl_pin, e;
	logic        start = 1'b0, pol = 1'b0, clamp_en = 1'b0, es_in = 1'b0;
	logic [5:0]  thr;
	int          bad_count = 0, cmp_count = 0, cyc = 0;
	int          lead_n, lead_at, clamp_n, start_at;

	always #4 pclk = ~pclk;

	sync_source_model i_src (.pclk(pclk), .start(start), .pol(pol), .clamp_en(clamp_en),
		.line_sync_in(ls_pin), .clamp_ext_in(cl_pin));

	sync_and_clamp_input_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_sync_in(ls_pin),
		.clamp_ext_in(cl_pin), .embedded_sync_input(es_in), .embedded_sync_output(es_out),
		.sog_threshold_code(thr), .line_sync_lead(lead), .clamp_out(clamp_out));

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cyc++;
		if (lead === 1'b1) begin
			lead_n++;
			lead_at = cyc;
		end
		if (clamp_out === 1'b1)
			clamp_n++;
		if (cyc > 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Request holds until pready is seen high at a rising edge; data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			bad_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One line of 45 counted cycles
	task run_line;
		repeat (12) @(posedge pclk);
		@(negedge pclk);
		lead_n = 0;
		clamp_n = 0;
		@(posedge pclk);
		start <= 1'b1;
		@(negedge pclk);
		start_at = cyc;
		@(posedge pclk);
		start <= 1'b0;
		repeat (43) @(posedge pclk);
		@(negedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		apb(1'b0, 12'h038, 32'h0);
		chk(r, 32'h00000000);
		apb(1'b0, 12'h03C, 32'h0);
		chk(r, 32'h00000040);
		apb(1'b0, 12'h040, 32'h0);
		chk(r, 32'h0000000E);
		chk({26'h0, thr}, 32'h0000000E);
		apb(1'b0, 12'h07C, 32'h0);
		chk({31'h0, e}, 32'h00000001);
	endtask

	// Lead comes early only when the selected edge opens the pulse
	task t_edge;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h038, {25'h0, i[1], 6'h00});
			pol <= i[0];
			run_line();
			chk(32'(lead_n), 32'h00000001);
			chk({31'h0, (lead_at - start_at) < 9}, {31'h0, i[1] == i[0]});
		end
	endtask

	task t_int;
		apb(1'b1, 12'h038, 32'h0);
		pol <= 1'b0;
		apb(1'b1, 12'h014, 32'h00000002);
		apb(1'b1, 12'h018, 32'h00000005);
		clamp_en <= 1'b1;
		run_line();
		chk(32'(clamp_n), 32'h00000005);
	endtask

	task t_ext;
		apb(1'b1, 12'h03C, 32'h000000C0);
		run_line();
		chk(32'(clamp_n), 32'h00000006);
		apb(1'b1, 12'h03C, 32'h00000080);
		run_line();
		chk(32'(clamp_n), 32'h00000027);
		apb(1'b1, 12'h03C, 32'h00000040);
	endtask

	task t_sog;
		apb(1'b1, 12'h040, 32'h00000028);
		apb(1'b0, 12'h040, 32'h0);
		chk(r, 32'h00000020);
		chk({26'h0, thr}, 32'h00000020);
		apb(1'b1, 12'h040, 32'h00000000);
		es_in <= 1'b1;
		// The write lands at the edge the task returns on, so look half a cycle later
		@(negedge pclk);
		chk({26'h0, thr}, 32'h00000000);
		repeat (4) @(negedge pclk);
		chk({31'h0, es_out}, 32'h00000001);
		@(posedge pclk);
		es_in <= 1'b0;
		repeat (5) @(negedge pclk);
		chk({31'h0, es_out}, 32'h00000000);
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_edge();
		t_int();
		t_ext();
		t_sog();
		end_of_test();
	end
endmodule
`default_nettype wire
